// ---- regulator_voltage_select_regs_bench.sv ----
// Directed bench for the voltage-select bank.
// Assumes vsel_bank and its checker are compiled first.
`timescale 1ns/1ps
`define CHK(g, w) begin n_checks++; if ((g) !== (w)) begin bad_count++; \
  $display("Error %0t: got %h want %h", $time, g, w); end end
module regulator_voltage_select_regs_bench;
  logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, fine = 1'b0, af, bf, fq;
  logic [7:0] adr = 8'h00, wd = 8'h00, rdat;
  logic [6:0] an, asl, bn, bs;
  logic [3:0] ln, ls;
  logic [7:0] da [5] = '{8'hAB, 8'hFF, 8'h54, 8'h81, 8'hC3};
  logic [7:0] ex [5] = '{8'hAB, 8'hFE, 8'h54, 8'h80, 8'hC3};
  int         bad_count = 0, n_checks = 0;
  always #2 clk = ~clk;
  vsel_bank u_vsel_bank (.CLK_SYS_I(clk), .RESET_I(rst), .ADDR_I(adr), .WR_EN_I(wr),
    .RD_EN_I(rd), .WDATA_I(wd), .BUCK_B_FINE_RANGE_I(fine), .RDATA_O(rdat),
    .BUCK_A_NORMAL_CODE_O(an), .BUCK_A_PASSIVE_FALL_SEL_O(af), .BUCK_A_SLEEP_CODE_O(asl),
    .BUCK_B_NORMAL_CODE_O(bn), .BUCK_B_PASSIVE_FALL_SEL_O(bf), .BUCK_B_SLEEP_CODE_O(bs),
    .BUCK_B_FINE_RANGE_O(fq), .LINEAR_REG_NORMAL_CODE_O(ln), .LINEAR_REG_SLEEP_CODE_O(ls));
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {adr, wd, wr} <= {a, d, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
  endtask : put
  task automatic get(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    {adr, rd} <= {a, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(rdat, e)
  endtask : get
  // ********
  // Scenarios
  // ********
  task automatic t_fields();
    for (int i = 0; i < 5; i++) put(8'(8'h96 + i), da[i]);
    repeat (2) @(posedge clk);
    #1 `CHK({an, af, asl, 1'b0}, {ex[0], ex[1]})
    `CHK({bn, bf, bs, 1'b0, ls, ln}, {ex[2], ex[3], ex[4]})
    for (int i = 0; i < 5; i++) get(8'(8'h96 + i), ex[i]);
  endtask : t_fields
  task automatic t_edge();
    put(8'h95, 8'hFF);
    put(8'h9B, 8'hFF);
    put(8'h96, 8'h00);
    put(8'h98, 8'h01);
    fine <= 1'b1;
    get(8'h95, 8'h00);
    get(8'h9B, 8'h00);
    `CHK({an, af, bn, bf, fq, ls, ln}, {8'h00, 8'h01, 1'b1, 8'hC3})
    `CHK({asl, bs}, {7'h7F, 7'h40})
  endtask : t_edge
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_fields();
    t_edge();
    end_sim();
  end
endmodule : regulator_voltage_select_regs_bench

// ---- vsel_bank.sv ----
// Voltage-select register bank for two bucks and one linear regulator.
// Assumes the management port delivers synchronous byte reads and writes.
`timescale 1ns/1ps
`include "vsel_regs.svh"
module vsel_bank (
  input  wire logic                 CLK_SYS_I,
  input  wire logic                 RESET_I,
  input  wire logic [7:0]           ADDR_I,
  input  wire logic                 WR_EN_I,
  input  wire logic                 RD_EN_I,
  input  wire vsel_pkg::byte_t      WDATA_I,
  input  wire logic                 BUCK_B_FINE_RANGE_I,
  output vsel_pkg::byte_t           RDATA_O,
  output vsel_pkg::buck_code_t      BUCK_A_NORMAL_CODE_O,
  output logic                      BUCK_A_PASSIVE_FALL_SEL_O,
  output vsel_pkg::buck_code_t      BUCK_A_SLEEP_CODE_O,
  output vsel_pkg::buck_code_t      BUCK_B_NORMAL_CODE_O,
  output logic                      BUCK_B_PASSIVE_FALL_SEL_O,
  output vsel_pkg::buck_code_t      BUCK_B_SLEEP_CODE_O,
  output logic                      BUCK_B_FINE_RANGE_O,
  output vsel_pkg::lin_code_t       LINEAR_REG_NORMAL_CODE_O,
  output vsel_pkg::lin_code_t       LINEAR_REG_SLEEP_CODE_O
);
  import vsel_pkg::*;
  // ****************************************
  // Decode
  // ****************************************
  vsel_decode_if dif ();
  vsel_decode u_dec (
    .addr_i (ADDR_I),
    .dec    (dif)
  );
  wire we_an = WR_EN_I && (dif.sel == SEL_A_NORMAL);
  wire we_as = WR_EN_I && (dif.sel == SEL_A_SLEEP);
  wire we_bn = WR_EN_I && (dif.sel == SEL_B_NORMAL);
  wire we_bs = WR_EN_I && (dif.sel == SEL_B_SLEEP);
  wire we_ln = WR_EN_I && (dif.sel == SEL_LINEAR);
  // Factory values are unknown here, so all fields clear at reset
  byte_t an_ff, as_ff, bn_ff, bs_ff, ln_ff;
  wire byte_t wsleep = {WDATA_I[`CODE_MSB:`CODE_LSB], `RSVD_ZERO};
  // ****************************************
  // Storage
  // ****************************************
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      an_ff <= `RESET_BYTE;
      as_ff <= `RESET_BYTE;
      bn_ff <= `RESET_BYTE;
      bs_ff <= `RESET_BYTE;
      ln_ff <= `RESET_BYTE;
    end else begin
      if (we_an) an_ff <= WDATA_I;
      if (we_as) as_ff <= wsleep;
      if (we_bn) bn_ff <= WDATA_I;
      if (we_bs) bs_ff <= wsleep;
      if (we_ln) ln_ff <= WDATA_I;
    end
  end
  // ****************************************
  // Readback
  // ****************************************
  wire byte_t rd_mux = (dif.sel == SEL_A_NORMAL) ? an_ff :
                       (dif.sel == SEL_A_SLEEP)  ? as_ff :
                       (dif.sel == SEL_B_NORMAL) ? bn_ff :
                       (dif.sel == SEL_B_SLEEP)  ? bs_ff :
                       (dif.sel == SEL_LINEAR)   ? ln_ff : `READ_UNMAPPED;
  // Outputs registered once more so every port leaves a flip-flop
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      RDATA_O                   <= `RESET_BYTE;
      BUCK_A_NORMAL_CODE_O      <= '0;
      BUCK_A_PASSIVE_FALL_SEL_O <= 1'h0;
      BUCK_A_SLEEP_CODE_O       <= '0;
      BUCK_B_NORMAL_CODE_O      <= '0;
      BUCK_B_PASSIVE_FALL_SEL_O <= 1'h0;
      BUCK_B_SLEEP_CODE_O       <= '0;
      BUCK_B_FINE_RANGE_O       <= 1'h0;
      LINEAR_REG_NORMAL_CODE_O  <= '0;
      LINEAR_REG_SLEEP_CODE_O   <= '0;
    end else begin
      if (RD_EN_I) RDATA_O <= rd_mux;
      BUCK_A_NORMAL_CODE_O      <= an_ff[`CODE_MSB:`CODE_LSB];
      BUCK_A_PASSIVE_FALL_SEL_O <= an_ff[`FALL_BIT];
      BUCK_A_SLEEP_CODE_O       <= as_ff[`CODE_MSB:`CODE_LSB];
      BUCK_B_NORMAL_CODE_O      <= bn_ff[`CODE_MSB:`CODE_LSB];
      BUCK_B_PASSIVE_FALL_SEL_O <= bn_ff[`FALL_BIT];
      BUCK_B_SLEEP_CODE_O       <= bs_ff[`CODE_MSB:`CODE_LSB];
      // Table choice is a strap from outside; it tags both buck B codes
      BUCK_B_FINE_RANGE_O       <= BUCK_B_FINE_RANGE_I;
      LINEAR_REG_NORMAL_CODE_O  <= ln_ff[`LIN_NRM_MSB:`LIN_NRM_LSB];
      LINEAR_REG_SLEEP_CODE_O   <= ln_ff[`LIN_SLP_MSB:`LIN_SLP_LSB];
    end
  end
endmodule : vsel_bank

// ---- vsel_bank_monitor.sv ----
// Port assertions for the voltage-select bank.
// Assumes a bind onto vsel_bank, one clock.
`timescale 1ns/1ps
module vsel_bank_monitor (
  input wire logic       CLK_SYS_I,
  input wire logic       RESET_I,
  input wire logic [7:0] ADDR_I,
  input wire logic       WR_EN_I,
  input wire logic       RD_EN_I,
  input wire logic [7:0] WDATA_I,
  input wire logic       BUCK_B_FINE_RANGE_I,
  input wire logic [7:0] RDATA_O,
  input wire logic [6:0] BUCK_A_NORMAL_CODE_O,
  input wire logic       BUCK_A_PASSIVE_FALL_SEL_O,
  input wire logic [6:0] BUCK_A_SLEEP_CODE_O,
  input wire logic [6:0] BUCK_B_NORMAL_CODE_O,
  input wire logic       BUCK_B_PASSIVE_FALL_SEL_O,
  input wire logic [6:0] BUCK_B_SLEEP_CODE_O,
  input wire logic       BUCK_B_FINE_RANGE_O,
  input wire logic [3:0] LINEAR_REG_NORMAL_CODE_O,
  input wire logic [3:0] LINEAR_REG_SLEEP_CODE_O
);
  // Idle writes show 00h, which no register owns
  wire [7:0] wa = WR_EN_I ? ADDR_I : 8'h00;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RESET_I);
  a_nrm_a: assert property (wa == 8'h96 |-> ##2
    {BUCK_A_NORMAL_CODE_O, BUCK_A_PASSIVE_FALL_SEL_O} == $past(WDATA_I, 2)) else $error("a");
  a_slp_a: assert property (wa == 8'h97 |-> ##2
    {BUCK_A_SLEEP_CODE_O, 1'b0} == ($past(WDATA_I, 2) & 8'hFE)) else $error("b");
  b_nrm_a: assert property (wa == 8'h98 |-> ##2
    {BUCK_B_NORMAL_CODE_O, BUCK_B_PASSIVE_FALL_SEL_O} == $past(WDATA_I, 2)) else $error("c");
  b_slp_a: assert property (wa == 8'h99 |-> ##2
    {BUCK_B_SLEEP_CODE_O, 1'b0} == ($past(WDATA_I, 2) & 8'hFE)) else $error("d");
  lin_pair_a: assert property (wa == 8'h9A |-> ##2
    {LINEAR_REG_SLEEP_CODE_O, LINEAR_REG_NORMAL_CODE_O} == $past(WDATA_I, 2)) else $error("e");
  fine_rng_a: assert property (!$past(RESET_I) |->
    BUCK_B_FINE_RANGE_O == $past(BUCK_B_FINE_RANGE_I)) else $error("f");
  unmap_rd_a: assert property (RD_EN_I && !(ADDR_I inside {[8'h96:8'h9A]}) |=>
    RDATA_O == 8'h00) else $error("g");
  rsvd_rd_a: assert property (RD_EN_I && ADDR_I inside {8'h97, 8'h99} |=>
    RDATA_O[0] == 1'b0) else $error("h");
endmodule : vsel_bank_monitor
bind vsel_bank vsel_bank_monitor u_vsel_bank_monitor (.*);

// ---- vsel_decode.sv ----
// Address decoder of the voltage-select bank.
// Assumes a byte address from the management port.
`timescale 1ns/1ps
`include "vsel_regs.svh"
module vsel_decode (
  input  wire logic [7:0] addr_i,
  vsel_decode_if.dec      dec
);
  import vsel_pkg::*;
  // ****************************************
  // Address match
  // ****************************************
  wire hit_an = (addr_i == `OFS_BUCK_A_NORMAL);
  wire hit_as = (addr_i == `OFS_BUCK_A_SLEEP);
  wire hit_bn = (addr_i == `OFS_BUCK_B_NORMAL);
  wire hit_bs = (addr_i == `OFS_BUCK_B_SLEEP);
  wire hit_ln = (addr_i == `OFS_LINEAR_PAIR);
  assign dec.sel = hit_an ? SEL_A_NORMAL :
                   hit_as ? SEL_A_SLEEP  :
                   hit_bn ? SEL_B_NORMAL :
                   hit_bs ? SEL_B_SLEEP  :
                   hit_ln ? SEL_LINEAR   : SEL_NONE;
endmodule : vsel_decode

// ---- vsel_decode_if.sv ----
// Decode result carried from the decoder to the register bank.
// Assumes one clock domain.
`timescale 1ns/1ps
interface vsel_decode_if;
  import vsel_pkg::*;
  reg_sel_t sel;
  modport dec (output sel);
  modport bank (input sel);
endinterface : vsel_decode_if

// ---- vsel_pkg.sv ----
// Types shared by the voltage-select bank.
// Assumes vsel_regs.svh supplies the offsets.
package vsel_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [6:0] buck_code_t;
  typedef logic [3:0] lin_code_t;
  typedef enum logic [2:0] {
    SEL_NONE     = 3'h0,
    SEL_A_NORMAL = 3'h1,
    SEL_A_SLEEP  = 3'h3,
    SEL_B_NORMAL = 3'h2,
    SEL_B_SLEEP  = 3'h6,
    SEL_LINEAR   = 3'h7
  } reg_sel_t;
endpackage : vsel_pkg

// ---- vsel_regs.svh ----
// Register map of the regulator voltage-select bank.
// Assumes byte-wide accesses from the serial management port logic.
`ifndef VSEL_REGS_SVH
`define VSEL_REGS_SVH
`define OFS_BUCK_A_NORMAL 8'h96
`define OFS_BUCK_A_SLEEP  8'h97
`define OFS_BUCK_B_NORMAL 8'h98
`define OFS_BUCK_B_SLEEP  8'h99
`define OFS_LINEAR_PAIR   8'h9A
`define CODE_MSB          7
`define CODE_LSB          1
`define FALL_BIT          0
`define LIN_SLP_MSB       7
`define LIN_SLP_LSB       4
`define LIN_NRM_MSB       3
`define LIN_NRM_LSB       0
`define RESET_BYTE        8'h00
`define RSVD_ZERO         1'h0
`define READ_UNMAPPED     8'h00
`endif
